//--- rtl/rfr_pkg.sv
// shared constants for the resolver fault reporting block
package rfr_pkg;

  // -------------------------------------------------------------------
  // fault indices
  // -------------------------------------------------------------------
  localparam int FLT_N       = 25;
  localparam int IZ_N        = 4;
  localparam int F_MODE      = 0;   // exciter mode field invalid
  localparam int F_EXT_OV    = 1;
  localparam int F_EXT_UV    = 2;
  localparam int F_EXT_ILIM  = 3;
  localparam int F_IZH0      = 4;   // four input high overvoltage flags
  localparam int F_IZL0      = 8;   // four input low overvoltage flags
  localparam int F_OPEN0     = 12;  // short, sin hi, cos hi, sin lo, cos lo
  localparam int OPEN_N      = 5;
  localparam int F_LOOP_ERR  = 17;
  localparam int F_CFG_CRC   = 18;
  localparam int F_USR_CRC   = 19;
  localparam int F_TRIM_CRC  = 20;
  localparam int F_BIST      = 21;
  localparam int F_RDBK      = 22;
  localparam int F_LOOP_OVF  = 23;
  localparam int F_GND_OPEN  = 24;

  // -------------------------------------------------------------------
  // per-fault attributes, one bit per fault index
  // -------------------------------------------------------------------
  localparam logic [FLT_N-1:0] HAS_MASK = 25'h003_fff6;  // owns a pin mask bit
  localparam logic [FLT_N-1:0] PIN_RPT  = 25'h13f_ffff;  // releases the fault pin
  localparam logic [FLT_N-1:0] EXC_KILL = 25'h167_ffff;  // turns the exciter off
  localparam logic [FLT_N-1:0] OVR_UV   = 25'h000_0004;
  localparam logic [FLT_N-1:0] OVR_IN   = 25'h003_fff0;
  localparam logic [FLT_N-1:0] OVR_BIST = 25'h020_0000;
  localparam logic [FLT_N-1:0] OVR_IO   = 25'h040_0000;

  // -------------------------------------------------------------------
  // encodings and reset values
  // -------------------------------------------------------------------
  localparam logic [1:0] MODE_BAD_LO = 2'h0;
  localparam logic [1:0] MODE_BAD_HI = 2'h3;
  localparam logic       EXC_EN_RST  = 1'h1;

  typedef enum logic [0:0]
  {
    ST_NORMAL = 1'b0,
    ST_FAULT  = 1'b1
  } rfr_state_t;

endpackage

//--- rtl/rfr_flag_cell.sv
// one sticky fault flag, cleared on read once its condition is gone
module rfr_flag_cell
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // condition and read strobe
  input  wire logic cond,
  input  wire logic rd_clr,
  // flag
  output logic      flag_r
);

  typedef struct packed
  {
    logic flag;
  } rfr_cell_t;

  rfr_cell_t st_r;
  rfr_cell_t st_nxt;

  // set wins over the read clear, so a live condition never vanishes
  always_comb
  begin
    st_nxt = st_r;
    if (cond)
      st_nxt.flag = 1'b1;
    else if (rd_clr)
      st_nxt.flag = 1'b0;
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign flag_r = st_r.flag;

endmodule

//--- rtl/rfr_fault_report.sv
// fault collection, fault pin, exciter shutdown and fault-state control
module rfr_fault_report
#(
  parameter int NUM_INPUTS = rfr_pkg::IZ_N
)
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  // exciter conditions: overvoltage, undervoltage, current limit
  input  wire logic [2:0]                exciter_raw,
  input  wire logic [1:0]                exciter_mask,
  input  wire logic [1:0]                exciter_mode_field,
  // sensor input conditions
  input  wire logic [NUM_INPUTS-1:0]     input_high_overvolt_raw,
  input  wire logic [NUM_INPUTS-1:0]     input_high_overvolt_mask,
  input  wire logic [NUM_INPUTS-1:0]     input_low_overvolt_raw,
  input  wire logic [NUM_INPUTS-1:0]     input_low_overvolt_mask,
  input  wire logic [4:0]                input_open_raw,
  input  wire logic [4:0]                input_open_mask,
  input  wire logic                      loop_input_err_raw,
  input  wire logic                      loop_input_err_mask,
  // digital conditions: config crc, user nvm crc, trim nvm crc
  input  wire logic [2:0]                crc_raw,
  input  wire logic                      bist_raw,
  input  wire logic                      loop_overflow_raw,
  input  wire logic                      ground_open_raw,
  // overrides
  input  wire logic                      exciter_undervolt_override,
  input  wire logic                      input_fault_override,
  input  wire logic                      bist_override,
  input  wire logic                      pin_readback_override,
  // software access
  input  wire logic                      flag_read_pulse,
  input  wire logic                      exciter_enable_wr,
  input  wire logic                      exciter_enable_wdata,
  // fault pin and clear input
  input  wire logic                      fault_clear_input,
  input  wire logic                      fault_pin_in,
  output logic                           fault_pin_out,
  output logic                           fault_pin_oe,
  // status
  output logic [rfr_pkg::FLT_N-1:0]      fault_flag_vec,
  output logic                           spi_fault_summary,
  output logic                           exciter_enable_bit,
  output logic                           loop_run
);

  // -------------------------------------------------------------------
  // elaboration check
  // -------------------------------------------------------------------
  generate
    if (NUM_INPUTS != rfr_pkg::IZ_N)
    begin : g_bad_inputs
      $error("rfr_fault_report serves exactly four sensor inputs");
    end
  endgenerate

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed
  {
    rfr_pkg::rfr_state_t state;
    logic                clr_prev;
    logic                clr_seen_low;
    logic                pin_oe;
    logic                exc_en;
    logic                run;
    logic                summary;
    logic                rdbk_prev;
  } rfr_main_t;

  rfr_main_t                 st_r;
  rfr_main_t                 st_nxt;
  logic [rfr_pkg::FLT_N-1:0] cond_vec;
  logic [rfr_pkg::FLT_N-1:0] mask_vec;
  logic [rfr_pkg::FLT_N-1:0] ovr_vec;
  logic [rfr_pkg::FLT_N-1:0] live_vec;
  logic                      mode_bad;
  logic                      rdbk_mism;
  logic                      pin_cond;
  logic                      kill_active;
  logic                      clr_rise;

  // -------------------------------------------------------------------
  // condition and mask vectors
  // -------------------------------------------------------------------
  // mode field codes that select no valid exciter mode
  assign mode_bad = (exciter_mode_field == rfr_pkg::MODE_BAD_LO) ||
                    (exciter_mode_field == rfr_pkg::MODE_BAD_HI);

  // pin settles a cycle after a change, so two mismatching samples are needed
  assign rdbk_mism = (fault_pin_in == st_r.pin_oe);

  always_comb
  begin
    cond_vec = '0;
    cond_vec[rfr_pkg::F_MODE]     = mode_bad;
    cond_vec[rfr_pkg::F_EXT_OV]   = exciter_raw[0];
    cond_vec[rfr_pkg::F_EXT_UV]   = exciter_raw[1];
    cond_vec[rfr_pkg::F_EXT_ILIM] = exciter_raw[2];
    cond_vec[rfr_pkg::F_IZH0 +: rfr_pkg::IZ_N] = input_high_overvolt_raw;
    cond_vec[rfr_pkg::F_IZL0 +: rfr_pkg::IZ_N] = input_low_overvolt_raw;
    cond_vec[rfr_pkg::F_OPEN0 +: rfr_pkg::OPEN_N] = input_open_raw;
    cond_vec[rfr_pkg::F_LOOP_ERR] = loop_input_err_raw;
    cond_vec[rfr_pkg::F_CFG_CRC]  = crc_raw[0];
    cond_vec[rfr_pkg::F_USR_CRC]  = crc_raw[1];
    cond_vec[rfr_pkg::F_TRIM_CRC] = crc_raw[2];
    cond_vec[rfr_pkg::F_BIST]     = bist_raw;
    cond_vec[rfr_pkg::F_RDBK]     = rdbk_mism & st_r.rdbk_prev;
    cond_vec[rfr_pkg::F_LOOP_OVF] = loop_overflow_raw;
    cond_vec[rfr_pkg::F_GND_OPEN] = ground_open_raw;
  end

  // faults without a mask bit can never be masked
  always_comb
  begin
    mask_vec = '0;
    mask_vec[rfr_pkg::F_EXT_OV] = exciter_mask[0];
    mask_vec[rfr_pkg::F_EXT_UV] = exciter_mask[1];
    mask_vec[rfr_pkg::F_IZH0 +: rfr_pkg::IZ_N]    = input_high_overvolt_mask;
    mask_vec[rfr_pkg::F_IZL0 +: rfr_pkg::IZ_N]    = input_low_overvolt_mask;
    mask_vec[rfr_pkg::F_OPEN0 +: rfr_pkg::OPEN_N] = input_open_mask;
    mask_vec[rfr_pkg::F_LOOP_ERR] = loop_input_err_mask;
    mask_vec = mask_vec & rfr_pkg::HAS_MASK;
  end

  // override groups spread over the faults they cover
  assign ovr_vec = ({rfr_pkg::FLT_N{exciter_undervolt_override}} & rfr_pkg::OVR_UV) |
                   ({rfr_pkg::FLT_N{input_fault_override}} & rfr_pkg::OVR_IN) |
                   ({rfr_pkg::FLT_N{bist_override}} & rfr_pkg::OVR_BIST) |
                   ({rfr_pkg::FLT_N{pin_readback_override}} & rfr_pkg::OVR_IO);

  // a masked fault only reaches its flag
  assign live_vec = cond_vec & ~mask_vec;

  // pin release is a plain or of the unmasked pin-reporting sources
  assign pin_cond = |(live_vec & rfr_pkg::PIN_RPT);

  // clear input held low is the evaluation hold that keeps the exciter up
  assign kill_active = fault_clear_input &&
                       (|(live_vec & rfr_pkg::EXC_KILL & ~ovr_vec));

  assign clr_rise = fault_clear_input && !st_r.clr_prev;

  // -------------------------------------------------------------------
  // fault flags
  // -------------------------------------------------------------------
  generate
    for (genvar i = 0; i < rfr_pkg::FLT_N; i++)
    begin : g_flag
      rfr_flag_cell u_cell
      (
        .sys_clk (sys_clk),
        .reset   (reset),
        .cond    (cond_vec[i]),
        .rd_clr  (flag_read_pulse),
        .flag_r  (fault_flag_vec[i])
      );
    end
  endgenerate

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.clr_prev  = fault_clear_input;
    st_nxt.rdbk_prev = rdbk_mism;
    st_nxt.summary   = |fault_flag_vec;
    case (st_r.state)
      rfr_pkg::ST_NORMAL:
      begin
        st_nxt.clr_seen_low = 1'b0;
        if (pin_cond)
          st_nxt.state = rfr_pkg::ST_FAULT;
      end
      rfr_pkg::ST_FAULT:
      begin
        // a falling edge arms the exit, the next rising edge completes it if no pin fault remains
        if (st_r.clr_prev && !fault_clear_input)
          st_nxt.clr_seen_low = 1'b1;
        if (clr_rise)
        begin
          st_nxt.clr_seen_low = 1'b0;
          if (st_r.clr_seen_low && !pin_cond)
            st_nxt.state = rfr_pkg::ST_NORMAL;
        end
      end
      default:
      begin
        st_nxt.state = rfr_pkg::ST_FAULT;
      end
    endcase
    // pin follows the state, so a short fault stays visible until cleared
    st_nxt.pin_oe = (st_nxt.state == rfr_pkg::ST_NORMAL) && !pin_cond;
    st_nxt.run    = (st_nxt.state == rfr_pkg::ST_NORMAL) && !pin_cond;
    // software may not re-enable the exciter while a protecting fault stands and the clear input is high
    if (kill_active)
      st_nxt.exc_en = 1'b0;
    else if (exciter_enable_wr)
      st_nxt.exc_en = exciter_enable_wdata;
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_r          <= '0;
      st_r.clr_prev <= 1'b1;
      st_r.pin_oe   <= 1'b1;
      st_r.exc_en   <= rfr_pkg::EXC_EN_RST;
      st_r.run      <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign fault_pin_out      = 1'b0;  // open drain only ever pulls low
  assign fault_pin_oe       = st_r.pin_oe;
  assign spi_fault_summary  = st_r.summary;
  assign exciter_enable_bit = st_r.exc_en;
  assign loop_run           = st_r.run;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  pin_release_a: assert property (pin_cond |=> !fault_pin_oe)
    else $error("fault pin not released on unmasked fault");
  pin_hold_a: assert property ((st_r.state == rfr_pkg::ST_NORMAL && !pin_cond)
    |=> fault_pin_oe)
    else $error("fault pin released without fault");
  clear_exit_a: assert property ((st_r.state == rfr_pkg::ST_FAULT
    && st_r.clr_seen_low && clr_rise && !pin_cond) |=> (loop_run && fault_pin_oe))
    else $error("toggle did not leave fault state");
  stay_fault_a: assert property ((st_r.state == rfr_pkg::ST_FAULT && !clr_rise)
    |=> !loop_run)
    else $error("fault state left without clear toggle");
  flag_set_a: assert property ((cond_vec != '0) |=>
    ((fault_flag_vec & $past(cond_vec)) == $past(cond_vec)))
    else $error("fault flag not set by its condition");
  flag_keep_a: assert property ((fault_flag_vec[rfr_pkg::F_USR_CRC] && !flag_read_pulse)
    |=> fault_flag_vec[rfr_pkg::F_USR_CRC])
    else $error("flag cleared without a read");
  hold_low_a: assert property ((!fault_clear_input && exciter_enable_bit
    && !exciter_enable_wr) |=> exciter_enable_bit)
    else $error("exciter dropped while clear input held low");
  kill_a: assert property (kill_active |=> !exciter_enable_bit[*2])
    else $error("exciter kept on by protecting fault");
  override_a: assert property ((cond_vec == (1 << rfr_pkg::F_RDBK))
    && pin_readback_override && exciter_enable_bit
    && !exciter_enable_wr |=> exciter_enable_bit)
    else $error("override did not keep exciter on");
  mode_a: assert property (mode_bad |=> fault_flag_vec[rfr_pkg::F_MODE])
    else $error("invalid exciter mode not flagged");
  ovf_pin_a: assert property ((cond_vec == (1 << rfr_pkg::F_LOOP_OVF))
    && st_r.state == rfr_pkg::ST_NORMAL |=> fault_pin_oe && loop_run)
    else $error("loop overflow touched the fault pin");
  loop_stop_a: assert property (pin_cond |=> !loop_run)
    else $error("tracking loop kept running in fault");
  // a software write lands whenever no protecting fault overrules it
  sw_write_a: assert property ((exciter_enable_wr && !kill_active)
    |=> exciter_enable_bit == $past(exciter_enable_wdata))
    else $error("exciter enable write lost");

  fault_entry_c: cover property (st_r.state == rfr_pkg::ST_NORMAL ##1
    st_r.state == rfr_pkg::ST_FAULT);
  fault_exit_c: cover property (st_r.state == rfr_pkg::ST_FAULT ##1
    st_r.state == rfr_pkg::ST_NORMAL);
  read_clear_c: cover property (fault_flag_vec != '0 ##1 fault_flag_vec == '0);
  exc_kill_c: cover property (exciter_enable_bit ##1 !exciter_enable_bit);
  hold_low_c: cover property (!fault_clear_input && ((live_vec & rfr_pkg::EXC_KILL) != '0)
    ##1 exciter_enable_bit);

endmodule

//--- bench/rfr_host_model.sv
// host controller model: fault pin pad with pull-up, clear input and flag reads
module rfr_host_model
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // fault pin pad
  input  wire logic fault_pin_out,
  input  wire logic fault_pin_oe,
  output logic      fault_pin_in,
  // host controls
  output logic      fault_clear_input,
  output logic      flag_read_pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  logic bad_r;

  // -------------------------------------------------------------------
  // pad and host drive
  // -------------------------------------------------------------------
  // pull-up wins when released; a commanded fault flips the driven level
  // pad faults are kept out of reset so the readback starts clean
  assign fault_pin_in = fault_pin_oe ? (fault_pin_out ^ (bad_r & !reset)) : 1'b1;

  // clear idles high, no read outstanding
  initial
  begin
    bad_r = 1'b0;
    fault_clear_input = 1'b1;
    flag_read_pulse = 1'b0;
  end

  // one-cycle flag read strobe
  task automatic read_flags();
    @(posedge sys_clk);
    flag_read_pulse <= 1'b1;
    @(posedge sys_clk);
    flag_read_pulse <= 1'b0;
  endtask

  // high-low-high, low phase kept far under the pulse limit
  task automatic toggle_clear();
    @(posedge sys_clk);
    fault_clear_input <= 1'b0;
    repeat (3) @(posedge sys_clk);
    fault_clear_input <= 1'b1;
  endtask

  // level hold on the clear input, test use only
  task automatic hold_clear(input logic lvl);
    @(posedge sys_clk);
    fault_clear_input <= lvl;
  endtask

  // broken pad for readback tests
  task automatic bad_pin(input logic on);
    @(posedge sys_clk);
    bad_r <= on;
  endtask
endmodule

//--- bench/tb_resolver_fault_reporting.sv
// self-checking bench for the resolver fault reporting block
module tb_resolver_fault_reporting;
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------------------------
  // stimulus and observed signals
  // -------------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  logic [2:0]  ex_raw  = 3'h0;
  logic [1:0]  ex_mask = 2'h0;
  logic [1:0]  mode    = 2'h1;
  logic [3:0]  hi_raw  = 4'h0;
  logic [3:0]  hi_mask = 4'h0;
  logic [3:0]  lo_raw  = 4'h0;
  logic [3:0]  lo_mask = 4'h0;
  logic [4:0]  op_raw  = 5'h00;
  logic [4:0]  op_mask = 5'h00;
  logic [1:0]  le      = 2'h0;   // raw, mask
  logic [2:0]  crc     = 3'h0;
  logic [2:0]  misc    = 3'h0;   // bist, overflow, ground open
  logic [3:0]  ovr     = 4'h0;   // readback, bist, input, undervolt
  logic        en_wr   = 1'b0;
  logic        en_wd   = 1'b0;
  wire logic   clr_in, rd_pulse, pin_in, pin_out, pin_oe, summary, exc_en, loop_run;
  wire logic [rfr_pkg::FLT_N-1:0] flags;
  int          num_errors = 0;
  int          tests_run  = 0;

  always #12.5 sys_clk = ~sys_clk;

  rfr_fault_report dut_u
  (
    .sys_clk(sys_clk), .reset(reset), .exciter_raw(ex_raw), .exciter_mask(ex_mask),
    .exciter_mode_field(mode), .input_high_overvolt_raw(hi_raw),
    .input_high_overvolt_mask(hi_mask), .input_low_overvolt_raw(lo_raw),
    .input_low_overvolt_mask(lo_mask), .input_open_raw(op_raw), .input_open_mask(op_mask),
    .loop_input_err_raw(le[1]), .loop_input_err_mask(le[0]), .crc_raw(crc),
    .bist_raw(misc[2]), .loop_overflow_raw(misc[1]), .ground_open_raw(misc[0]),
    .exciter_undervolt_override(ovr[0]), .input_fault_override(ovr[1]),
    .bist_override(ovr[2]), .pin_readback_override(ovr[3]), .flag_read_pulse(rd_pulse),
    .exciter_enable_wr(en_wr), .exciter_enable_wdata(en_wd), .fault_clear_input(clr_in),
    .fault_pin_in(pin_in), .fault_pin_out(pin_out), .fault_pin_oe(pin_oe),
    .fault_flag_vec(flags), .spi_fault_summary(summary), .exciter_enable_bit(exc_en),
    .loop_run(loop_run)
  );

  rfr_host_model host_u
  (
    .sys_clk(sys_clk), .reset(reset), .fault_pin_out(pin_out), .fault_pin_oe(pin_oe),
    .fault_pin_in(pin_in), .fault_clear_input(clr_in), .flag_read_pulse(rd_pulse)
  );

  // -------------------------------------------------------------------
  // shared helpers
  // -------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // sample after the edge's updates have landed
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic sw_en(input logic v);
    @(posedge sys_clk);
    {en_wr, en_wd} <= {1'b1, v};
    @(posedge sys_clk);
    en_wr <= 1'b0;
  endtask

  // flag, pin and exciter one edge after the condition
  task automatic expect_st(input int idx, input logic oe, input logic ex);
    settle();
    check(32'(flags[idx]), 32'h1);
    check(32'(pin_oe), 32'(oe));
    check(32'(exc_en), 32'(ex));
  endtask

  // conditions removed before the host clears anything
  task automatic recover();
    @(posedge sys_clk);
    {ex_raw, ex_mask, hi_raw, hi_mask, lo_raw, lo_mask, op_raw, op_mask} <= '0;
    {le, crc, misc, ovr} <= '0;
    mode <= 2'h1;
    host_u.read_flags();
    host_u.toggle_clear();
    sw_en(1'b1);
    settle();
    check(32'(pin_oe), 32'h1);
    check(32'(loop_run), 32'h1);
    check(32'(flags), 32'h0);
    check(32'(exc_en), 32'h1);
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic s_reset();
    settle();
    check(32'(pin_oe), 32'h1);
    check(32'(pin_out), 32'h0);
    check(32'(exc_en), 32'(rfr_pkg::EXC_EN_RST));
    check(32'({flags, summary}), 32'h0);
  endtask

  task automatic s_mode();
    for (int c = 0; c < 4; c++)
    begin
      @(posedge sys_clk);
      mode <= 2'(c);
      if (2'(c) == rfr_pkg::MODE_BAD_LO || 2'(c) == rfr_pkg::MODE_BAD_HI)
      begin
        expect_st(rfr_pkg::F_MODE, 1'b0, 1'b0);
        recover();
      end
      else
      begin
        settle();
        check(32'(flags), 32'h0);
      end
    end
  endtask

  task automatic s_inputs();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      {hi_raw[i], hi_mask[i]} <= 2'h3;
      expect_st(rfr_pkg::F_IZH0 + i, 1'b1, 1'b1);
      recover();
      @(posedge sys_clk);
      {lo_raw[i], ovr[1]} <= 2'h3;
      expect_st(rfr_pkg::F_IZL0 + i, 1'b0, 1'b1);
      recover();
    end
    for (int j = 0; j < rfr_pkg::OPEN_N; j++)
    begin
      @(posedge sys_clk);
      op_raw[j] <= 1'b1;
      expect_st(rfr_pkg::F_OPEN0 + j, 1'b0, 1'b0);
      recover();
    end
  endtask

  // overrides and masks on the other fault groups
  task automatic s_overrides();
    int idx_t[6] = '{rfr_pkg::F_EXT_UV, rfr_pkg::F_BIST, rfr_pkg::F_LOOP_ERR,
                     rfr_pkg::F_EXT_OV, rfr_pkg::F_IZL0, rfr_pkg::F_OPEN0};
    logic [5:0] oe_t = 6'b11_1100;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge sys_clk);
      case (k)
        0: {ex_raw, ovr} <= {3'h2, 4'h1};
        1: {misc, ovr} <= {3'h4, 4'h4};
        2: le <= 2'h3;
        3: {ex_raw, ex_mask} <= {3'h1, 2'h1};
        4: {lo_raw, lo_mask} <= 8'h11;
        default: {op_raw, op_mask} <= 10'h021;
      endcase
      expect_st(idx_t[k], oe_t[k], 1'b1);
      recover();
    end
  endtask

  task automatic s_crc();
    @(posedge sys_clk);
    crc[0] <= 1'b1;
    expect_st(rfr_pkg::F_CFG_CRC, 1'b0, 1'b0);
    sw_en(1'b1);
    settle();
    check(32'(exc_en), 32'h0);
    recover();
    @(posedge sys_clk);
    crc[1] <= 1'b1;
    expect_st(rfr_pkg::F_USR_CRC, 1'b0, 1'b1);
    recover();
    @(posedge sys_clk);
    crc[2] <= 1'b1;
    expect_st(rfr_pkg::F_TRIM_CRC, 1'b0, 1'b1);
    recover();
    @(posedge sys_clk);
    ex_raw[2] <= 1'b1;
    expect_st(rfr_pkg::F_EXT_ILIM, 1'b0, 1'b0);
    recover();
    @(posedge sys_clk);
    misc[1] <= 1'b1;
    expect_st(rfr_pkg::F_LOOP_OVF, 1'b1, 1'b1);
    check(32'(loop_run), 32'h1);
    recover();
  endtask

  task automatic s_rdbk();
    int n;
    for (int o = 0; o < 2; o++)
    begin
      @(posedge sys_clk);
      ovr[3] <= 1'(o);
      host_u.bad_pin(1'b1);
      n = 0;
      while (flags[rfr_pkg::F_RDBK] !== 1'b1 && n < 8)
      begin
        settle();
        n++;
      end
      check(32'(n < 8), 32'h1);
      if (n == 8)
        print_verdict();
      settle();
      settle();
      check(32'({exc_en, pin_oe}), 32'({1'(o), 1'b1}));
      host_u.bad_pin(1'b0);
      recover();
    end
  endtask

  // clear held low keeps the exciter on until released
  task automatic s_hold();
    host_u.hold_clear(1'b0);
    @(posedge sys_clk);
    crc[0] <= 1'b1;
    expect_st(rfr_pkg::F_CFG_CRC, 1'b0, 1'b1);
    host_u.hold_clear(1'b1);
    settle();
    settle();
    check(32'(exc_en), 32'h0);
    recover();
  endtask

  // transient ground open: sticky flag, refused toggle, then proper exit
  task automatic s_clear();
    @(posedge sys_clk);
    misc[0] <= 1'b1;
    expect_st(rfr_pkg::F_GND_OPEN, 1'b0, 1'b0);
    check(32'(loop_run), 32'h0);
    settle();
    check(32'(summary), 32'h1);
    host_u.toggle_clear();
    repeat (3) settle();
    check(32'(pin_oe), 32'h0);
    host_u.read_flags();
    settle();
    check(32'(flags[rfr_pkg::F_GND_OPEN]), 32'h1);
    @(posedge sys_clk);
    misc[0] <= 1'b0;
    repeat (3) settle();
    check(32'({flags[rfr_pkg::F_GND_OPEN], pin_oe}), 32'h2);
    host_u.read_flags();
    settle();
    check(32'({flags[rfr_pkg::F_GND_OPEN], summary}), 32'h0);
    host_u.toggle_clear();
    repeat (3) settle();
    check(32'({pin_oe, loop_run}), 32'h3);
    recover();
  endtask

  // software disable, quiet time, then re-enable
  task automatic s_sw();
    sw_en(1'b0);
    settle();
    check(32'({exc_en, pin_oe}), 32'h1);
    repeat (4000) @(posedge sys_clk);
    sw_en(1'b1);
    settle();
    check(32'(exc_en), 32'h1);
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    s_reset();
    s_mode();
    s_inputs();
    s_overrides();
    s_crc();
    s_rdbk();
    s_hold();
    s_clear();
    s_sw();
    print_verdict();
  end
endmodule
